// File: common/cpf_pkg.sv
// Shared constants and types for the charging port protection block
package cpf_pkg;
   // Clock and timer widths
   localparam int CLK_MHZ = 200;
   localparam int CLK_NS = 5;
   localparam int TMR_W = 27;
   localparam int PH_W = 10;

   // Long intervals, in microseconds
   localparam int HICCUP_ON_US = 4100;
   localparam int HICCUP_OFF_US = 524000;
   localparam int FLT_REL_US = 16400;
   localparam int SOFT_START_US = 2000;
   localparam int HICCUP_ON_CYC = HICCUP_ON_US * CLK_MHZ;
   localparam int HICCUP_OFF_CYC = HICCUP_OFF_US * CLK_MHZ;
   localparam int FLT_REL_CYC = FLT_REL_US * CLK_MHZ;
   localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;

   // Switching cycle timing, in nanoseconds
   localparam int BLANK_NS = 50;
   localparam int DEAD_NS = 10;
   localparam int PERIOD_NS = 2500;
   localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PERIOD_CYC = PERIOD_NS / CLK_NS;

   // Output voltage targets, in millivolts
   localparam logic [12:0] VOUT_NOM_MV = 13'h1388;
   localparam logic [12:0] VOUT_HOT_MV = 13'h12a2;
   localparam logic [12:0] COMP_MAX_MV = 13'h0190;
   localparam logic [12:0] PORT_MAX_MV = 13'h157c;
   localparam int COMP_SHIFT = 10;

   // Positions in the synchronised input vector
   localparam int IN_TRIP = 0;
   localparam int IN_PEAK = 1;
   localparam int IN_VALLEY = 2;
   localparam int IN_AUX = 3;
   localparam int IN_BUS = 4;
   localparam int IN_VGOOD = 5;
   localparam int IN_WARM = 6;
   localparam int IN_HOT = 7;
   localparam int IN_OVERTEMP_SHUTDOWN = 8;
   localparam int NIN = 9;

   // Timer slots
   localparam int TM_AUX = 0;
   localparam int TM_BUS = 1;
   localparam int TM_REL = 2;
   localparam int TM_SS = 3;
   localparam int NTM = 4;

   typedef enum logic [1:0] {
      ADV_DEF = 2'h0,
      ADV_1P5 = 2'h1,
      ADV_3A = 2'h2
   } cpf_adv_t;

   typedef enum logic [1:0] {
      HC_NORM = 2'h0,
      HC_LIM = 2'h1,
      HC_OFF = 2'h2,
      HC_ON = 2'h3
   } cpf_hc_t;

   typedef enum logic [2:0] {
      BK_OFF = 3'h0,
      BK_DHS = 3'h1,
      BK_HS = 3'h2,
      BK_DLS = 3'h3,
      BK_LS = 3'h4
   } cpf_bk_t;

   typedef enum logic [1:0] {
      PW_SS = 2'h0,
      PW_RUN = 2'h1,
      PW_SD = 2'h2
   } cpf_pw_t;
endpackage

// File: common/cpf_tmr_if.sv
// Request and done lines between the control logic and an interval timer
`timescale 1ns/100ps
interface cpf_tmr_if;
   import cpf_pkg::*;
   logic run;
   logic [TMR_W-1:0] limit;
   logic done;
   modport timer (input run, input limit, output done);
   modport user (output run, output limit, input done);
endinterface

// File: hw/cpf_timer.sv
// Interval timer that counts while run is high and restarts when it drops
`timescale 1ns/100ps
module cpf_timer
   import cpf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   cpf_tmr_if.timer tb
);
   logic [TMR_W-1:0] cnt_q;
   wire at_end = (cnt_q == tb.limit - TMR_W'(1));

   assign tb.done = tb.run && at_end;

   always_ff @(posedge clk_sys)
   begin
      if (rst || !tb.run || tb.done)
         cnt_q <= '0; // RL17
      else
         cnt_q <= cnt_q + TMR_W'(1); // RL17
   end

   timer_restart_a: assert property (@(posedge clk_sys) disable iff (rst) // RL17
      !tb.run |=> cnt_q == '0)
      else $error("timer did not restart when run dropped");
   timer_wrap_a: assert property (@(posedge clk_sys) disable iff (rst) // RL17
      tb.done |=> cnt_q == '0)
      else $error("timer did not wrap after done");
endmodule

// File: hw/cpf_top.sv
// Protection, thermal and fault flag control for a charging port
// Summary of operation
// [RL1] Peak current sensed after blanking; fixed peak limit independent of duty.
// [RL2] Low side stays on past cycle end until below valley, then dead time.
// [RL3] Auxiliary limit: constant current; after 4.1 ms hiccup 4.1 ms on, 524 off.
// [RL4] Output target rises with load; added part capped 400 mV, below 5.5 V.
// [RL5] Warm sense stage drops a 3 A advertisement to 1.5 A.
// [RL6] Hot sense stage switches advertisement to default USB power.
// [RL7] Hot sense stage also lowers the output target to 4.77 V.
// [RL8] Die over shutdown threshold turns off; cooling restarts with soft start.
// [RL9] Fault pin released in shutdown, start-up and normal operation; the code holds it low through thermal shutdown and for 16.4 ms after it clears.
// [RL10] Fault pin driven low on bus hiccup or thermal shutdown.
// [RL11] Fault released only once cleared and bus voltage is back.
// [RL12] Bus overcurrent: hiccup, flag after 4.1 ms, release after 16.4 ms.
// [RL13] Fault flag held for the whole bus overload.
// [RL14] Over-temperature disables at once and flags without deglitch.
// [RL15] Fault flag is active low.
// [RL16] Bus limit beyond 4.1 ms cycles the port 524 ms off, 4.1 ms on.
// [RL17] Intervals counted in clock cycles; timers restart when cause clears.
// [RL18] Leaving a sense stage restores previous advertisement and voltage.
`timescale 1ns/100ps
module cpf_top
#(
   parameter int HICCUP_ON_CYC = cpf_pkg::HICCUP_ON_CYC,
   parameter int HICCUP_OFF_CYC = cpf_pkg::HICCUP_OFF_CYC,
   parameter int FLT_REL_CYC = cpf_pkg::FLT_REL_CYC,
   parameter int SOFT_START_CYC = cpf_pkg::SOFT_START_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pwm_trip,
   input wire logic hs_over_peak,
   input wire logic ls_over_valley,
   input wire logic aux_at_limit,
   input wire logic bus_over_limit,
   input wire logic bus_vgood,
   input wire logic ts_warm,
   input wire logic ts_hot,
   input wire logic die_over_sd,
   input wire cpf_pkg::cpf_adv_t adv_cfg,
   input wire logic [11:0] load_ma,
   input wire logic [7:0] drop_comp_gain_input,
   output logic high_side_switch,
   output logic low_side_switch,
   output logic aux_switch_on,
   output logic aux_cc_mode,
   output logic bus_switch_on,
   output logic soft_start,
   output cpf_pkg::cpf_adv_t advert,
   output logic [12:0] vout_target_mv,
   output logic fault_n_o,
   output logic fault_n_oe
);
   import cpf_pkg::*;

   // Input synchronisers
   logic [NIN-1:0] raw;
   logic [NIN-1:0] s;

   assign raw = {die_over_sd, ts_hot, ts_warm, bus_vgood, bus_over_limit,
                 aux_at_limit, ls_over_valley, hs_over_peak, pwm_trip};

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++)
      begin : g_sync
         logic [2:0] sh_q;
         logic f_q;
         always_ff @(posedge clk_sys)
         begin
            if (rst)
            begin
               sh_q <= 3'h0;
               f_q <= 1'b0;
            end
            else
            begin
               sh_q <= {sh_q[1:0], raw[gi]};
               if (sh_q[1] == sh_q[2])
                  f_q <= sh_q[2];
            end
         end
         assign s[gi] = f_q;
      end
   endgenerate

   wire overtemp_shutdown_s = s[IN_OVERTEMP_SHUTDOWN];
   wire warm_s = s[IN_WARM];
   wire hot_s = s[IN_HOT];

   // Interval timers
   cpf_tmr_if t [NTM] ();
   generate
      for (gi = 0; gi < NTM; gi++)
      begin : g_tmr
         cpf_timer u_tmr (
            .clk_sys(clk_sys),
            .rst(rst),
            .tb(t[gi])
         );
      end
   endgenerate

   // Power sequencing: soft start, run, thermal shutdown
   cpf_pw_t pw_q;
   cpf_pw_t pw_d;
   wire run = (pw_q != PW_SD) && !overtemp_shutdown_s; // RL14

   assign t[TM_SS].run = (pw_q == PW_SS);
   assign t[TM_SS].limit = TMR_W'(SOFT_START_CYC);

   always_comb
   begin
      pw_d = pw_q;
      case (pw_q)
         PW_SS: if (t[TM_SS].done) pw_d = PW_RUN;
         PW_RUN: pw_d = PW_RUN;
         PW_SD: if (!overtemp_shutdown_s) pw_d = PW_SS; // RL8
         default: pw_d = PW_SS;
      endcase
      if (overtemp_shutdown_s)
         pw_d = PW_SD; // RL8 RL14
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         pw_q <= PW_SS;
      else
         pw_q <= pw_d;
   end

   assign soft_start = (pw_q == PW_SS);

   // Hiccup control, slot 0 auxiliary output, slot 1 bus switch
   cpf_hc_t hc_q [2];
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_hc
         cpf_hc_t hc_d;
         wire over = (gi == 0) ? s[IN_AUX] : s[IN_BUS];
         wire done = t[gi].done;

         assign t[gi].run = (hc_q[gi] == HC_LIM && over) || // RL17
                            hc_q[gi] == HC_OFF || hc_q[gi] == HC_ON;
         assign t[gi].limit = (hc_q[gi] == HC_OFF) ? TMR_W'(HICCUP_OFF_CYC)
                                                   : TMR_W'(HICCUP_ON_CYC);

         always_comb
         begin
            hc_d = hc_q[gi];
            case (hc_q[gi])
               HC_NORM: if (over) hc_d = HC_LIM;
               HC_LIM:
               begin
                  if (!over)
                     hc_d = HC_NORM;
                  else if (done)
                     hc_d = HC_OFF; // RL3 RL16
               end
               HC_OFF: if (done) hc_d = HC_ON; // RL3 RL16
               HC_ON: if (done) hc_d = over ? HC_OFF : HC_NORM; // RL3 RL16
               default: hc_d = HC_NORM;
            endcase
            if (!run)
               hc_d = HC_NORM;
         end

         always_ff @(posedge clk_sys)
         begin
            if (rst)
               hc_q[gi] <= HC_NORM;
            else
               hc_q[gi] <= hc_d;
         end
      end
   endgenerate

   assign aux_switch_on = run && hc_q[0] != HC_OFF; // RL3
   assign aux_cc_mode = aux_switch_on && s[IN_AUX]; // RL3
   assign bus_switch_on = run && hc_q[1] != HC_OFF; // RL12 RL16

   // Fault flag
   logic fault_q;
   wire bus_fault = (hc_q[1] == HC_OFF) || (hc_q[1] == HC_ON); // RL12 RL13
   wire flt_set = overtemp_shutdown_s || bus_fault; // RL10 RL14
   wire rel_ok = !overtemp_shutdown_s && hc_q[1] == HC_NORM && s[IN_VGOOD]; // RL11

   assign t[TM_REL].run = fault_q && rel_ok; // RL12 RL17
   assign t[TM_REL].limit = TMR_W'(FLT_REL_CYC);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         fault_q <= 1'b0; // RL9
      else if (flt_set)
         fault_q <= 1'b1; // RL10
      else if (t[TM_REL].done)
         fault_q <= 1'b0; // RL11 RL12
   end

   assign fault_n_o = 1'b0; // RL15
   assign fault_n_oe = fault_q; // RL9 RL15

   // Buck switching cycle
   cpf_bk_t bk_q;
   cpf_bk_t bk_d;
   logic [PH_W-1:0] per_q;
   logic [PH_W-1:0] ph_q;
   logic hold_q;
   wire cycle_end = (per_q == PH_W'(PERIOD_CYC - 1));
   wire blank_done = (ph_q >= PH_W'(BLANK_CYC)); // RL1
   wire dead_done = (ph_q >= PH_W'(DEAD_CYC - 1)); // RL2
   wire peak_hit = blank_done && (s[IN_TRIP] || s[IN_PEAK]); // RL1
   wire valley_hi = s[IN_VALLEY];

   always_comb
   begin
      bk_d = bk_q;
      case (bk_q)
         BK_OFF: bk_d = BK_DHS;
         BK_DHS: if (dead_done) bk_d = BK_HS; // RL2
         BK_HS: if (peak_hit || cycle_end) bk_d = BK_DLS; // RL1
         BK_DLS: if (dead_done) bk_d = BK_LS;
         BK_LS: if ((cycle_end || hold_q) && !valley_hi) bk_d = BK_DHS; // RL2
         default: bk_d = BK_OFF;
      endcase
      if (!run)
         bk_d = BK_OFF; // RL8
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         bk_q <= BK_OFF;
         per_q <= '0;
         ph_q <= '0;
         hold_q <= 1'b0;
      end
      else
      begin
         bk_q <= bk_d;
         per_q <= (cycle_end || !run) ? '0 : per_q + PH_W'(1);
         ph_q <= (bk_d != bk_q) ? '0 : ph_q + PH_W'(1);
         hold_q <= (bk_q == BK_LS && bk_d == BK_LS && (cycle_end || hold_q));
      end
   end

   assign high_side_switch = (bk_q == BK_HS);
   assign low_side_switch = (bk_q == BK_LS);

   // Advertisement and output target
   cpf_adv_t adv_d;
   logic [19:0] comp_prod;
   logic [12:0] comp_raw;
   logic [12:0] comp_mv;
   logic [12:0] base_mv;
   logic [13:0] sum_mv;
   logic [12:0] tgt_mv;

   assign adv_d = hot_s ? ADV_DEF : // RL6 RL18
                  (warm_s && adv_cfg == ADV_3A) ? ADV_1P5 : adv_cfg; // RL5 RL18
   assign comp_prod = load_ma * drop_comp_gain_input;
   assign comp_raw = 13'(comp_prod >> COMP_SHIFT);
   assign comp_mv = (comp_raw > COMP_MAX_MV) ? COMP_MAX_MV : comp_raw; // RL4
   assign base_mv = hot_s ? VOUT_HOT_MV : VOUT_NOM_MV; // RL7 RL18
   assign sum_mv = {1'b0, base_mv} + {1'b0, comp_mv}; // RL4
   assign tgt_mv = (sum_mv >= {1'b0, PORT_MAX_MV}) ?
                   PORT_MAX_MV - 13'h0001 : sum_mv[12:0]; // RL4

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         advert <= ADV_DEF;
         vout_target_mv <= VOUT_NOM_MV;
      end
      else
      begin
         advert <= adv_d;
         vout_target_mv <= tgt_mv;
      end
   end

   // Checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   blank_sense_a: assert property ( // RL1
      (bk_q == BK_HS && bk_d == BK_DLS && !cycle_end) |-> ph_q >= BLANK_CYC)
      else $error("peak current acted on inside blanking");
   valley_hold_a: assert property ( // RL2
      (bk_q == BK_LS && cycle_end && valley_hi && run) |=> low_side_switch)
      else $error("low side released above valley limit");
   dead_time_a: assert property ( // RL2
      $fell(low_side_switch) |-> !high_side_switch ##1 !high_side_switch)
      else $error("no dead time before high side");
   aux_hiccup_a: assert property ( // RL3
      (hc_q[0] == HC_LIM && t[TM_AUX].done && run) |=> !aux_switch_on)
      else $error("auxiliary output not off after limit interval");
   port_cap_a: assert property ( // RL4
      vout_target_mv < PORT_MAX_MV)
      else $error("output target above port ceiling");
   warm_adv_a: assert property ( // RL5
      (warm_s && !hot_s && adv_cfg == ADV_3A) |=> advert == ADV_1P5)
      else $error("warm stage did not drop advertisement");
   hot_stage_a: assert property ( // RL6
      hot_s |=> advert == ADV_DEF &&
                vout_target_mv <= VOUT_HOT_MV + COMP_MAX_MV)
      else $error("hot stage did not lower advertisement and target");
   overtemp_shutdown_off_a: assert property ( // RL14
      overtemp_shutdown_s |=> !bus_switch_on && !high_side_switch && fault_n_oe)
      else $error("thermal shutdown not immediate");
   fault_hold_a: assert property ( // RL13
      bus_fault |=> fault_n_oe)
      else $error("fault flag dropped during bus overload");
   fault_rel_a: assert property ( // RL11
      $fell(fault_n_oe) |-> $past(rel_ok) && !$past(flt_set))
      else $error("fault released before condition cleared");
endmodule

// File: dv/cpf_sink.sv
// Model of a portable device loading the bus
`timescale 1ns/100ps
module cpf_sink
(
   input wire logic clk_sys,
   input wire logic sw_on,
   input wire logic heavy,
   output logic over_q,
   output logic good_q
);
   // Overload draws current only while the switch conducts
   always_ff @(posedge clk_sys)
   begin
      over_q <= sw_on & heavy;
      good_q <= sw_on & ~heavy;
   end
endmodule

// File: dv/tb.sv
// Self-checking bench for the charging port protection block
`timescale 1ns/100ps
module tb;
   import cpf_pkg::*;
   localparam int ON = 20;
   localparam int OFF = 60;
   localparam int REL = 40;
   localparam int SS = 30;
   localparam int LIMIT_NS = 50000;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic pwm_trip = 1'b0;
   logic peak = 1'b0;
   logic valley = 1'b0;
   logic aux_lim = 1'b0;
   logic heavy = 1'b0;
   logic warm = 1'b0;
   logic hot = 1'b0;
   logic die = 1'b0;
   cpf_adv_t adv_cfg = ADV_3A;
   logic [11:0] load_ma = 12'h000;
   logic [7:0] gain = 8'h00;
   logic hs, ls, aux_on, aux_cc, bus_on, ss_o, f_o, f_oe;
   logic bus_over, vgood;
   cpf_adv_t advert;
   logic [12:0] vout;
   wire fault_pin = f_oe ? f_o : 1'b1;
   int n_mismatch = 0;
   int checks_done = 0;
   int n;

   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   cpf_top #(.HICCUP_ON_CYC(ON), .HICCUP_OFF_CYC(OFF),
      .FLT_REL_CYC(REL), .SOFT_START_CYC(SS)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .pwm_trip(pwm_trip),
      .hs_over_peak(peak), .ls_over_valley(valley),
      .aux_at_limit(aux_lim), .bus_over_limit(bus_over),
      .bus_vgood(vgood), .ts_warm(warm), .ts_hot(hot),
      .die_over_sd(die), .adv_cfg(adv_cfg), .load_ma(load_ma),
      .drop_comp_gain_input(gain), .high_side_switch(hs),
      .low_side_switch(ls), .aux_switch_on(aux_on),
      .aux_cc_mode(aux_cc), .bus_switch_on(bus_on),
      .soft_start(ss_o), .advert(advert), .vout_target_mv(vout),
      .fault_n_o(f_o), .fault_n_oe(f_oe));

   cpf_sink u_sink (.clk_sys(clk_sys), .sw_on(bus_on),
      .heavy(heavy), .over_q(bus_over), .good_q(vgood));

   task automatic cy(input int c);
      repeat (c) @(negedge clk_sys);
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: return f_oe;
         1: return bus_on;
         2: return hs;
         3: return ls;
         4: return ss_o;
         default: return aux_on;
      endcase
   endfunction

   // Waits a bounded number of cycles for a level, n counts them
   task automatic wt(input int s, input logic v, input int lim);
      n = 0;
      while (sig(s) !== v && n < lim)
      begin
         cy(1);
         n++;
      end
   endtask

   task automatic t_idle();
      cy(6);
      chk(fault_pin, 1'b1);
      chk(f_o, 1'b0);
      chk(advert, ADV_3A);
      chk(vout, 13'h1388);
      load_ma = 12'h400;
      gain = 8'h64;
      cy(6);
      chk(vout, 13'h13ec);
      load_ma = 12'hfff;
      gain = 8'hff;
      cy(6);
      chk(vout, 13'h1518);
      $display("t_idle done");
   endtask

   task automatic t_temp();
      warm = 1'b1;
      cy(6);
      chk(advert, ADV_1P5);
      hot = 1'b1;
      cy(6);
      chk(advert, ADV_DEF);
      chk(vout, 13'h1432);
      hot = 1'b0;
      cy(6);
      chk(advert, ADV_1P5);
      chk(vout, 13'h1518);
      warm = 1'b0;
      cy(6);
      chk(advert, ADV_3A);
      // Warm stage leaves a lower configured advertisement alone
      adv_cfg = ADV_DEF;
      warm = 1'b1;
      cy(6);
      chk(advert, ADV_DEF);
      warm = 1'b0;
      adv_cfg = ADV_3A;
      cy(6);
      $display("t_temp done");
   endtask

   task automatic t_bus();
      // Short overload first, so the limit timer must restart
      heavy = 1'b1;
      cy(ON - 4);
      heavy = 1'b0;
      cy(6);
      heavy = 1'b1;
      wt(0, 1'b1, ON + 20);
      chk(n >= ON, 1'b1);
      chk(n <= ON + 8, 1'b1);
      chk(fault_pin, 1'b0);
      chk(bus_on, 1'b0);
      wt(1, 1'b1, OFF + 20);
      chk(n >= OFF - 2, 1'b1);
      chk(f_oe, 1'b1);
      heavy = 1'b0;
      wt(0, 1'b0, REL + ON + 30);
      chk(n >= REL, 1'b1);
      chk(bus_on & vgood, 1'b1);
      $display("t_bus done");
   endtask

   task automatic t_therm();
      die = 1'b1;
      wt(0, 1'b1, 8);
      chk(n <= 6, 1'b1);
      cy(1);
      chk({hs, ls, aux_on, bus_on}, 4'h0);
      die = 1'b0;
      wt(4, 1'b1, 10);
      chk(ss_o, 1'b1);
      wt(4, 1'b0, SS + 10);
      chk(n >= SS - 2, 1'b1);
      wt(0, 1'b0, REL + 20);
      chk(f_oe, 1'b0);
      $display("t_therm done");
   endtask

   task automatic t_aux();
      aux_lim = 1'b1;
      cy(6);
      chk(aux_cc, 1'b1);
      wt(5, 1'b0, ON + 10);
      chk(n >= ON - 8, 1'b1);
      wt(5, 1'b1, OFF + 10);
      chk(n >= OFF - 2, 1'b1);
      aux_lim = 1'b0;
      cy(ON + 10);
      chk(aux_on, 1'b1);
      $display("t_aux done");
   endtask

   task automatic t_buck();
      peak = 1'b1;
      // Skip an on phase already under way, then time a fresh one
      wt(2, 1'b0, 600);
      wt(2, 1'b1, 600);
      wt(2, 1'b0, 600);
      chk(n >= BLANK_CYC - 1, 1'b1);
      chk(n <= BLANK_CYC + 2, 1'b1);
      peak = 1'b0;
      valley = 1'b1;
      wt(3, 1'b1, 600);
      cy(PERIOD_CYC + 20);
      chk({hs, ls}, 2'h1);
      valley = 1'b0;
      wt(3, 1'b0, 8);
      chk(n >= 2, 1'b1);
      wt(2, 1'b1, 8);
      chk(n >= DEAD_CYC - 1 && n <= DEAD_CYC + 1, 1'b1);
      // Regulation trip also waits out the blanking interval
      pwm_trip = 1'b1;
      wt(2, 1'b0, 600);
      chk(n >= BLANK_CYC - 1, 1'b1);
      chk(n <= BLANK_CYC + 2, 1'b1);
      pwm_trip = 1'b0;
      $display("t_buck done");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #LIMIT_NS;
      n_mismatch++;
      $display("watchdog expired");
      conclude();
   end

   initial
   begin
      cy(12);
      rst = 1'b0;
      t_idle();
      t_temp();
      t_bus();
      t_therm();
      t_aux();
      t_buck();
      conclude();
   end
endmodule
